// ### pkg/param_abort_pkg.sv
// constants for the parameter channel abort handler
// assumes eight-byte messages, byte 1 in bits 7:0, byte n in 8n-1:8n-8
package param_abort_pkg;

  localparam int MSG_BYTES = 8;
  localparam int MSG_W     = MSG_BYTES * 8;

  // service byte fields
  localparam int SVC_REQ_LO = 0;
  localparam int SVC_REQ_HI = 2;
  localparam int SVC_RSV    = 3;
  localparam int SVC_LEN_LO = 4;
  localparam int SVC_LEN_HI = 5;
  localparam int SVC_HS     = 6;
  localparam int SVC_STAT   = 7;

  localparam logic [2:0] REQ_NONE = 3'h0;
  localparam logic [2:0] REQ_EXT  = 3'h4;
  localparam logic [1:0] LEN_FOUR = 2'h3;
  localparam logic [1:0] LEN_NONE = 2'h0;

  // message byte positions (low bit of each field)
  localparam int POS_SVC  = 0;
  localparam int POS_SUB  = 8;
  localparam int POS_IDX  = 16;
  localparam int POS_CODE = 32;

  localparam logic [7:0]  SUB_ZERO  = 8'h00;
  localparam logic [15:0] IDX_ZERO  = 16'h0000;
  localparam logic [31:0] CODE_NONE = 32'h0000_0000;
  localparam logic [63:0] MSG_ZERO  = 64'h0000_0000_0000_0000;

  // transfer state, gray along idle -> write/read
  typedef enum logic [1:0] {
    XFER_IDLE  = 2'b00,
    XFER_WRITE = 2'b01,
    XFER_READ  = 2'b10
  } xfer_type;

endpackage

// ### src/param_channel_segment_abort.sv
// abort handling for segmented transfers over the cyclic parameter channel
// assumes req_valid marks one master message per cyclic exchange, same clk;
// initiate and segment answers come from neighbouring logic, which must
// yield the response slot whenever abort_rsp is high
//
// What this block does
// - drive abort: request field zero, status set
// - drive abort: bit 3 zero, length bits 11
// - error code bytes 5-8, subindex, index
// - echo master handshake bit in answers
// - aborted write: discard received segments
// - master abort length bits ignored, data zero
// - answer master abort with all-zero error status
`timescale 1ns/1ns
module param_channel_segment_abort #(
  parameter int MSG_BYTES = param_abort_pkg::MSG_BYTES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // master request of this cyclic exchange
  input  wire logic        req_valid,
  input  wire logic [63:0] req_msg,
  // initiate of a new transfer, decoded by the initiate logic
  input  wire logic        init_start,
  input  wire logic        init_write,
  input  wire logic [7:0]  init_subindex,
  input  wire logic [15:0] init_index,
  // drive side fault that ends the running transfer
  input  wire logic        drive_abort,
  input  wire logic [31:0] drive_code,
  // abort response message and transfer status flags
  output logic             abort_rsp,
  output logic [63:0]      rsp_msg,
  output logic             write_discard,
  output logic             read_aborted,
  output logic             outside_seg,
  output logic             busy
);

  localparam int BYTE_W     = 8;
  localparam int CODE_W     = $bits(param_abort_pkg::CODE_NONE);
  localparam int CODE_BYTES = CODE_W / BYTE_W;

  // the byte lanes below are laid out for the eight-byte channel only
  if (MSG_BYTES != param_abort_pkg::MSG_BYTES) begin
    $error("param_channel_segment_abort serves eight-byte messages only");
  end
  // the error code has to reach the last message byte, class first
  if (param_abort_pkg::POS_CODE + CODE_W != param_abort_pkg::MSG_W) begin
    $error("error code field does not end at the last message byte");
  end
  if (CODE_BYTES * BYTE_W != CODE_W) begin
    $error("error code must be a whole number of bytes");
  end

  typedef struct packed {
    param_abort_pkg::xfer_type st;
    logic                      pend;
    logic [31:0]               code;
    logic [7:0]                sub;
    logic [15:0]               idx;
    logic                      rsp_v;
    logic [63:0]               msg;
    logic                      discard;
    logic                      rd_abort;
    logic                      outside;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  logic [7:0] svc;
  logic       is_ext;
  logic       m_abort;
  logic       active;
  logic [7:0] err_svc;

  // both answers are built beside the state, so a branch only picks one
  logic [CODE_W-1:0] code_swap;
  logic              was_write;
  logic              was_read;
  logic [63:0]       drv_msg;
  logic [63:0]       mst_msg;

  assign svc     = req_msg[param_abort_pkg::POS_SVC +: 8];
  assign is_ext  = svc[param_abort_pkg::SVC_REQ_HI:param_abort_pkg::SVC_REQ_LO]
                   == param_abort_pkg::REQ_EXT;
  // length bits are not looked at once status is set
  assign m_abort = is_ext && svc[param_abort_pkg::SVC_STAT];
  assign active  = state_r.st != param_abort_pkg::XFER_IDLE;

  // error status service byte: F0 or B0 by the echoed handshake
  always_comb begin
    err_svc = 8'h00;
    err_svc[param_abort_pkg::SVC_REQ_HI:param_abort_pkg::SVC_REQ_LO] =
      param_abort_pkg::REQ_NONE;
    err_svc[param_abort_pkg::SVC_RSV] = 1'b0;
    err_svc[param_abort_pkg::SVC_LEN_HI:param_abort_pkg::SVC_LEN_LO] =
      param_abort_pkg::LEN_FOUR;
    err_svc[param_abort_pkg::SVC_HS] = svc[param_abort_pkg::SVC_HS];
    err_svc[param_abort_pkg::SVC_STAT] = 1'b1;
  end

  // the error class leaves first, so the highest code byte takes byte 5
  for (genvar b = 0; b < CODE_BYTES; b++) begin
    assign code_swap[b*BYTE_W +: BYTE_W] =
      state_r.code[(CODE_BYTES-1-b)*BYTE_W +: BYTE_W];
  end

  // which side drops its data depends on the kind of transfer that ends
  always_comb begin
    was_write = 1'b0;
    was_read  = 1'b0;
    case (state_r.st)
      param_abort_pkg::XFER_WRITE: begin
        was_write = 1'b1;
      end
      param_abort_pkg::XFER_READ: begin
        was_read = 1'b1;
      end
      default: begin
        was_write = 1'b0;
        was_read  = 1'b0;
      end
    endcase
  end

  // drive fault answer names the object of the open transfer
  always_comb begin
    drv_msg = param_abort_pkg::MSG_ZERO;
    drv_msg[param_abort_pkg::POS_SVC +: BYTE_W] = err_svc;
    drv_msg[param_abort_pkg::POS_SUB +: BYTE_W] = state_r.sub;
    drv_msg[param_abort_pkg::POS_IDX +: 16] = state_r.idx;
    drv_msg[param_abort_pkg::POS_CODE +: CODE_W] = code_swap;
  end

  // master abort answer: no object and no drive fault to report
  always_comb begin
    mst_msg = param_abort_pkg::MSG_ZERO;
    mst_msg[param_abort_pkg::POS_SVC +: BYTE_W] = err_svc;
    mst_msg[param_abort_pkg::POS_SUB +: BYTE_W] =
      param_abort_pkg::SUB_ZERO;
    mst_msg[param_abort_pkg::POS_IDX +: 16] =
      param_abort_pkg::IDX_ZERO;
    mst_msg[param_abort_pkg::POS_CODE +: CODE_W] =
      param_abort_pkg::CODE_NONE;
  end

  always_comb begin
    state_nxt          = state_r;
    state_nxt.rsp_v    = 1'b0;
    state_nxt.discard  = 1'b0;
    state_nxt.rd_abort = 1'b0;
    state_nxt.outside  = 1'b0;

    // a fault only matters while a transfer runs; it waits for the next
    // master message because the drive answers only inside an exchange
    if (drive_abort && active) begin
      state_nxt.pend = 1'b1;
      state_nxt.code = drive_code;
    end

    if (init_start) begin
      state_nxt.st   = init_write ? param_abort_pkg::XFER_WRITE
                                  : param_abort_pkg::XFER_READ;
      state_nxt.sub  = init_subindex;
      state_nxt.idx  = init_index;
      state_nxt.pend = 1'b0;
    end

    if (req_valid) begin
      if (m_abort) begin
        // master abort wins over a pending drive fault
        state_nxt.rsp_v    = 1'b1;
        state_nxt.msg      = mst_msg;
        state_nxt.discard  = was_write;
        state_nxt.rd_abort = was_read;
        state_nxt.st       = param_abort_pkg::XFER_IDLE;
        state_nxt.pend     = 1'b0;
      end else if (state_r.pend && active) begin
        // any segments taken so far die with the transfer
        state_nxt.rsp_v    = 1'b1;
        state_nxt.msg      = drv_msg;
        state_nxt.discard  = was_write;
        state_nxt.rd_abort = was_read;
        state_nxt.st       = param_abort_pkg::XFER_IDLE;
        state_nxt.pend     = 1'b0;
      end else if (is_ext && !active && !init_start) begin
        // segment with no transfer open; the segment logic refuses it
        state_nxt.outside = 1'b1;
      end
    end

    if (rst) begin
      state_nxt.st       = param_abort_pkg::XFER_IDLE;
      state_nxt.pend     = 1'b0;
      state_nxt.code     = param_abort_pkg::CODE_NONE;
      state_nxt.sub      = param_abort_pkg::SUB_ZERO;
      state_nxt.idx      = param_abort_pkg::IDX_ZERO;
      state_nxt.rsp_v    = 1'b0;
      state_nxt.msg      = param_abort_pkg::MSG_ZERO;
      state_nxt.discard  = 1'b0;
      state_nxt.rd_abort = 1'b0;
      state_nxt.outside  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    state_r <= state_nxt;
  end

  assign abort_rsp     = state_r.rsp_v;
  assign rsp_msg       = state_r.msg;
  assign write_discard = state_r.discard;
  assign read_aborted  = state_r.rd_abort;
  assign outside_seg   = state_r.outside;
  assign busy          = active;

endmodule

// ### dv/param_master_model.sv
// master model: sends one request per go pulse
// released data lines show the inverse of the last value
`timescale 1ns/1ns
module param_master_model (
  input  wire logic   clk, go, stop,
  output logic        req_valid = 1'h0,
  output logic [63:0] req_msg = 64'h0);
  logic hs_r = 1'h0;
  wire logic [7:0] svc = {stop, !hs_r, {2{!stop}}, 4'h4};
  always @(posedge clk) begin
    req_valid <= #5 go;
    hs_r <= hs_r ^ go;
    if (go) req_msg <= #5 {stop ? 48'h0 : 48'h6655_4433_2211, 8'h00, svc};
    else req_msg <= #5 ~req_msg;
  end
endmodule

// ### dv/segment_abort_monitor.sv
// assertions on the abort handler
// bound to the block, sees only its ports
`timescale 1ns/1ns
module segment_abort_monitor (
  input wire logic        clk, rst, req_valid, init_start, abort_rsp,
  input wire logic        write_discard, read_aborted, outside_seg, busy,
  input wire logic [63:0] req_msg, rsp_msg);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic ext = req_valid && req_msg[2:0] == 3'h4 && !init_start;
  svc_byte_a: assert property
    (abort_rsp |-> (rsp_msg[7:0] & 8'hbf) == 8'hb0) else $error("svc");
  hs_echo_a: assert property
    (abort_rsp |-> rsp_msg[6] == $past(req_msg[6])) else $error("hs");
  answer_time_a: assert property
    (abort_rsp |-> $past(req_valid)) else $error("late");
  zero_answer_a: assert property
    (ext && req_msg[7] |=> abort_rsp && !rsp_msg[63:8]) else $error("zero");
  write_drop_a: assert property
    (write_discard |-> abort_rsp && $past(busy)) else $error("wdrop");
  read_drop_a: assert property
    (read_aborted |-> abort_rsp && !write_discard) else $error("rdrop");
  back_idle_a: assert property
    (ext && req_msg[7] |=> !busy) else $error("idle");
  outside_flag_a: assert property
    (ext && !req_msg[7] && !busy |=> outside_seg) else $error("out");
endmodule
bind param_channel_segment_abort segment_abort_monitor mon_i (
  .clk           (clk),
  .rst           (rst),
  .req_valid     (req_valid),
  .init_start    (init_start),
  .abort_rsp     (abort_rsp),
  .write_discard (write_discard),
  .read_aborted  (read_aborted),
  .outside_seg   (outside_seg),
  .busy          (busy),
  .req_msg       (req_msg),
  .rsp_msg       (rsp_msg));

// ### dv/param_channel_segment_abort_test.sv
// abort handler test bench around the master model
// clk is 20 MHz, inputs move 5 ns after each rising edge
`timescale 1ns/1ns
module param_channel_segment_abort_test;
  bit          clk, go, stop, hs, init_start, init_write, drive_abort;
  bit          rst = 1'h1;
  logic        req_valid, abort_rsp, write_discard, read_aborted;
  logic        outside_seg, busy;
  logic [63:0] req_msg, rsp_msg;
  logic [7:0]  sub_in  = 8'h5a;
  logic [15:0] idx_in  = 16'h2345;
  logic [31:0] code_in = 32'h0605_0011;
  int          err_count, n_tests;
  always #25 clk = !clk;
  param_master_model param_master_model_i (
    .clk       (clk),
    .go        (go),
    .stop      (stop),
    .req_valid (req_valid),
    .req_msg   (req_msg));
  param_channel_segment_abort param_channel_segment_abort_i (
    .clk           (clk),
    .rst           (rst),
    .req_valid     (req_valid),
    .req_msg       (req_msg),
    .init_start    (init_start),
    .init_write    (init_write),
    .init_subindex (sub_in),
    .init_index    (idx_in),
    .drive_abort   (drive_abort),
    .drive_code    (code_in),
    .abort_rsp     (abort_rsp),
    .rsp_msg       (rsp_msg),
    .write_discard (write_discard),
    .read_aborted  (read_aborted),
    .outside_seg   (outside_seg),
    .busy          (busy));
  task automatic chk(string what, logic [63:0] seen, exp);
    n_tests++;
    err_count += int'(seen !== exp);
    if (seen !== exp)
      $display("Error %s expected %h seen %h", what, exp, seen);
  endtask
  task automatic send(bit ab);
    {go, stop, hs} = {1'h1, ab, !hs};
    @(posedge clk) #5;
    {go, drive_abort} = 2'h0;
    @(posedge clk) #5;
  endtask
  // leaves a drive fault raised, taken with the next request
  task automatic open(bit wr);
    {init_start, init_write} = {1'h1, wr};
    @(posedge clk) #5;
    {init_start, drive_abort} = 2'h1;
  endtask
  task automatic t_read();
    open(1'h0);
    send(1'h1);
    chk("answer", {abort_rsp, read_aborted, write_discard, busy},
        4'hc);
    chk("rsp", rsp_msg, {56'h0, 1'h1, hs, 6'h30});
    $display("master abort done");
  endtask
  task automatic t_write();
    open(1'h1);
    send(1'h0);
    chk("answer", {abort_rsp, write_discard, busy}, 3'h6);
    chk("rsp", rsp_msg, {56'h11_0005_0623_455a, 1'h1, hs, 6'h30});
    drive_abort = 1'h1;
    send(1'h0);
    chk("outside", {abort_rsp, outside_seg}, 2'h1);
    $display("write fault done");
  endtask
  // master abort on a write and when idle, drive fault on a read, reset
  task automatic t_mixed();
    open(1'h1);
    send(1'h1);
    chk("wr master", {abort_rsp, read_aborted, write_discard, busy},
        4'ha);
    chk("wr rsp", rsp_msg, {56'h0, 1'h1, hs, 6'h30});
    send(1'h1);
    chk("idle master", {abort_rsp, read_aborted, write_discard, busy},
        4'h8);
    chk("idle rsp", rsp_msg, {56'h0, 1'h1, hs, 6'h30});
    {sub_in, idx_in, code_in} = {8'h01, 16'h6041, 32'h0800_0020};
    open(1'h0);
    send(1'h0);
    chk("rd fault", {abort_rsp, read_aborted, write_discard, busy},
        4'hc);
    chk("rd rsp", rsp_msg, {56'h20_0000_0860_4101, 1'h1, hs, 6'h30});
    open(1'h1);
    rst = 1'h1;
    @(posedge clk) #5;
    {rst, drive_abort} = 2'h0;
    chk("reset", busy, 1'h0);
    send(1'h0);
    chk("after reset", {abort_rsp, busy, outside_seg}, 3'h1);
    $display("mixed aborts done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #5 rst = 1'h0;
    t_read();
    t_write();
    t_mixed();
    wrap_up();
  end
  initial begin
    #10000 err_count++;
    wrap_up();
  end
endmodule
